// ==== verilog/flash_cmd_pkg.sv ====
`default_nettype none
package flash_cmd_pkg;

  // Opcodes handled by the interpreter
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h62;
  localparam logic [7:0] OP_CHIP_ERASE_C = 8'hC7;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;

  // Field positions inside the status-write data byte
  localparam int PROTECT_FIELD_POS = 2;
  localparam int LOCK_FIELD_POS = 7;

  // Reset and shipping values
  localparam logic PROTECT_SHIP_VALUE = 1'b0;
  localparam logic LOCK_RESET_VALUE = 1'b0;
  localparam logic LATCH_RESET_VALUE = 1'b0;
  localparam logic ERROR_RESET_VALUE = 1'b0;

  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int CHIP_ERASE_TIME_NS = 1000000;

  // Link framing
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] BYTE_CNT_MAX = 2'h3;

  // Erase sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASING = 2'b01,
    ST_FINISH = 2'b10
  } erase_state_e;

  // What the link side knows about the frame that just ended
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] data;
    logic opcode_done;
    logic data_done;
    logic aligned;
  } frame_result_s;

  // Status bits shown to the rest of the device
  typedef struct packed {
    logic write_enable_latch;
    logic array_protect_bit;
    logic protect_lock_bit;
    logic erase_program_error_flag;
    logic busy;
    logic hw_locked;
  } status_s;

endpackage : flash_cmd_pkg
`default_nettype wire

// ==== verilog/flash_erase_protect_cmds.sv ====
// How it works
// R01 - Opcodes 60h, 62h and C7h all start the same full-array erase.
// R02 - Chip erase is refused unless the write-enable latch is already set.
// R03 - Chip erase takes no address, ignores trailing bytes, starts at chip-select release.
// R04 - No erase if release comes before a full opcode or off a byte boundary.
// R05 - Protected array or misaligned release: skip erase and clear the write-enable latch.
// R06 - Busy shows during erase; the latch is cleared before the erase ends.
// R07 - Any byte failing to erase sets the erase/program error flag.
// R08 - Write enable sets the latch at release, trailing bytes ignored.
// R09 - Write disable clears the latch at release, trailing bytes ignored.
// R10 - Program, erase, OTP and status writes need the latch set beforehand.
// R11 - Incomplete or misaligned write enable/disable leaves the latch unchanged.
// R12 - Protect bit set guards the whole array against program and erase.
// R13 - Protect bit lives in nonvolatile storage and ships as zero.
// R14 - Write-protect asserted with lock bit set freezes both bits, status writes ignored.
// R15 - Host unlocks by deasserting write-protect, then clearing the lock bit.
// R16 - With write-protect held asserted, a set lock bit clears only by power cycle.
// R17 - Write-protect deasserted: lock bit can be set, protect bit stays writable.
// R18 - Write-protect high: lock bit may be cleared when one, set when zero.
`timescale 1ns/10ps
`default_nettype none
module flash_erase_protect_cmds #(
  parameter int CHIP_ERASE_TIME = flash_cmd_pkg::CHIP_ERASE_TIME_NS
) (
  // System clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Serial link from the host
  input wire logic spi_clk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  input wire logic wp_n_in,
  // Nonvolatile protect storage
  input wire logic nv_blank_in,
  input wire logic nv_protect_in,
  output logic nv_write_out,
  output logic nv_protect_out,
  // Memory array
  input wire logic erase_fail_in,
  output logic erase_active_out,
  output logic array_write_allowed_out,
  // Status
  output var flash_cmd_pkg::status_s status_out
);
  import flash_cmd_pkg::*;

  // Erase length in system cycles, rounded up
  localparam int CHIP_ERASE_CYCLES = (CHIP_ERASE_TIME + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = $clog2(CHIP_ERASE_CYCLES + 1);

  // A sequencer shorter than two cycles is refused at elaboration time
  if (CHIP_ERASE_CYCLES < 2) begin : g_bad_erase_time
    $error("chip erase time must cover at least two clock cycles");
  end

  // Any of the three chip-erase opcodes
  function automatic logic is_chip_erase(input logic [7:0] op);
    is_chip_erase = (op == OP_CHIP_ERASE_A) || (op == OP_CHIP_ERASE_B) ||
                    (op == OP_CHIP_ERASE_C);
  endfunction : is_chip_erase

  // ---------------------------------------------------------------
  // Link side, clocked by the host's serial clock
  // ---------------------------------------------------------------
  logic link_rst;
  logic [2:0] bit_pos;
  logic [1:0] byte_cnt;
  logic [6:0] shift;
  logic frame_tog;
  frame_result_s result;
  logic [7:0] next_byte;

  assign next_byte = {shift, sdi_in};

  // Link logic is held in reset from the system side; the serial clock
  // is idle during reset so this async clear cannot race an edge
  always_ff @(posedge clk_sys_in) begin
    link_rst <= sys_rst_in;
  end

  // Bit and byte position inside a frame; chip-select high clears them
  always_ff @(posedge spi_clk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      bit_pos <= 3'h0;
      byte_cnt <= 2'h0;
    end else begin
      bit_pos <= bit_pos + 3'h1;
      if (bit_pos == BIT_LAST && byte_cnt != BYTE_CNT_MAX) begin
        byte_cnt <= byte_cnt + 2'h1;
      end
    end
  end

  // Serial data shift, most significant bit first
  always_ff @(posedge spi_clk_in or posedge link_rst) begin
    if (link_rst) begin
      shift <= 7'h00;
    end else begin
      shift <= next_byte[6:0];
    end
  end

  // Frame summary; it survives chip-select release so the system side
  // can read it once the frame is over and the serial clock has stopped
  always_ff @(posedge spi_clk_in or posedge link_rst) begin
    if (link_rst) begin
      result <= '0;
      frame_tog <= 1'b0;
    end else begin
      result.aligned <= (bit_pos == BIT_LAST); // see R04 see R11
      if (bit_pos == 3'h0 && byte_cnt == 2'h0) begin
        // First edge of a new frame: forget the last one
        result.opcode_done <= 1'b0;
        result.data_done <= 1'b0;
        frame_tog <= ~frame_tog;
      end
      if (bit_pos == BIT_LAST && byte_cnt == 2'h0) begin
        result.opcode <= next_byte;
        result.opcode_done <= 1'b1;
      end
      // Only the first byte after the opcode is kept; later ones are ignored
      if (bit_pos == BIT_LAST && byte_cnt == 2'h1) begin // see R03 see R08 see R09
        result.data <= next_byte;
        result.data_done <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // System side
  // ---------------------------------------------------------------
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;
  logic wp_meta;
  logic wp_n_sync;

  // Chip select, frame toggle and write-protect pass two flops each
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      wp_meta <= 1'b1;
      wp_n_sync <= 1'b1;
    end else begin
      cs_meta <= cs_n_in;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      tog_meta <= frame_tog;
      tog_sync <= tog_meta;
      wp_meta <= wp_n_in;
      wp_n_sync <= wp_meta;
    end
  end

  logic release_evt;
  logic new_frame;

  // A frame counts only if the host clocked at least one bit in it;
  // the toggle settles many serial periods before chip select rises
  assign release_evt = cs_sync & ~cs_prev;
  assign new_frame = tog_sync != tog_seen;

  // Remember which frame has been consumed
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      tog_seen <= 1'b0;
    end else if (release_evt) begin
      tog_seen <= tog_sync;
    end
  end

  // Protection and sequencer state
  logic wr_latch;
  logic protect;
  logic lock;
  logic error_flag;
  erase_state_e state;
  erase_state_e next_state;
  logic [CNT_W-1:0] erase_cnt;
  logic hw_locked;
  logic busy;

  assign busy = state != ST_IDLE; // see R06
  // Lock needs both the pin asserted (low) and the lock bit set
  assign hw_locked = ~wp_n_sync & lock; // see R14 see R16 see R17

  // Commands decoded at the end of a frame; the result words are stable
  // here because the serial clock does not run while chip select is high
  logic cmd_valid;
  logic full_opcode;
  logic ce_cmd;
  logic ce_start;
  logic ce_reject;
  logic wren_cmd;
  logic wrdi_cmd;
  logic sw_cmd;
  logic sw_apply;

  // Commands are ignored while the array is busy erasing
  assign cmd_valid = release_evt & new_frame & ~busy;
  assign full_opcode = cmd_valid & result.opcode_done; // see R04 see R11
  assign ce_cmd = full_opcode & is_chip_erase(result.opcode); // see R01
  // Start needs alignment, a set latch and an unprotected array
  assign ce_start = ce_cmd & result.aligned & wr_latch & ~protect; // see R02 see R03 see R10 see R12
  // Misaligned release or protected array drops the latch
  assign ce_reject = ce_cmd & (~result.aligned | (wr_latch & protect)); // see R05
  assign wren_cmd = full_opcode & result.aligned & (result.opcode == OP_WRITE_ENABLE); // see R08
  assign wrdi_cmd = full_opcode & result.aligned & (result.opcode == OP_WRITE_DISABLE); // see R09
  // Status write needs the data byte and a set latch
  assign sw_cmd = full_opcode & result.data_done & result.aligned &
                  (result.opcode == OP_STATUS_WRITE) & wr_latch; // see R10
  // Hardware lock stops the status write from changing the protect and lock bits
  assign sw_apply = sw_cmd & ~hw_locked; // see R14

  // Write-enable latch; incomplete or misaligned enable/disable leave it alone
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wr_latch <= LATCH_RESET_VALUE;
    end else if (wren_cmd) begin
      wr_latch <= 1'b1; // see R08
    end else if (wrdi_cmd || ce_reject || sw_cmd) begin
      wr_latch <= 1'b0; // see R09 see R05
    end else if (ce_start) begin
      wr_latch <= 1'b0; // see R06
    end
  end

  // Protect bit is loaded from nonvolatile storage at reset; a blank
  // store reads as the shipping value
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      protect <= nv_blank_in ? PROTECT_SHIP_VALUE : nv_protect_in; // see R13
    end else if (sw_apply) begin
      protect <= result.data[PROTECT_FIELD_POS]; // see R17
    end
  end

  // Lock bit is volatile, so only a power cycle (reset) clears it
  // while the pin is held asserted
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      lock <= LOCK_RESET_VALUE; // see R16
    end else if (sw_apply) begin
      lock <= result.data[LOCK_FIELD_POS]; // see R15 see R17 see R18
    end
  end

  // Every accepted protect change is pushed out to the store
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      nv_write_out <= 1'b0;
      nv_protect_out <= PROTECT_SHIP_VALUE;
    end else begin
      nv_write_out <= sw_apply; // see R13
      if (sw_apply) begin
        nv_protect_out <= result.data[PROTECT_FIELD_POS];
      end
    end
  end

  // Erase sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (ce_start) begin
          next_state = ST_ERASING; // see R03
        end
      end
      ST_ERASING: begin
        if (erase_cnt == CNT_W'(CHIP_ERASE_CYCLES - 1)) begin
          next_state = ST_FINISH;
        end
      end
      ST_FINISH: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Self-timed erase length
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      erase_cnt <= '0;
    end else if (state == ST_ERASING) begin
      erase_cnt <= erase_cnt + CNT_W'(1);
    end else begin
      erase_cnt <= '0;
    end
  end

  // The array erases and verifies while this level is high
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      erase_active_out <= 1'b0;
    end else begin
      erase_active_out <= next_state == ST_ERASING; // see R06
    end
  end

  // Error flag: cleared when a new erase starts, set by any failing byte;
  // a failure in the same cycle as the clear wins
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      error_flag <= ERROR_RESET_VALUE;
    end else if (state == ST_ERASING && erase_fail_in) begin
      error_flag <= 1'b1; // see R07
    end else if (ce_start) begin
      error_flag <= 1'b0;
    end
  end

  // Other array-writing commands elsewhere in the device are gated here,
  // so that one place owns the latch and protection check
  assign array_write_allowed_out = wr_latch & ~protect & ~busy; // see R10 see R12

  // Status as seen by status reads; one assignment so the word has one driver
  assign status_out = '{
    write_enable_latch: wr_latch,
    array_protect_bit: protect,
    protect_lock_bit: lock,
    erase_program_error_flag: error_flag,
    busy: busy, // see R06
    hw_locked: hw_locked
  };

endmodule : flash_erase_protect_cmds
`default_nettype wire

// ==== sim/flash_erase_protect_cmds_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module flash_erase_protect_cmds_chk #(
  parameter int CHIP_ERASE_TIME = 100
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Link and pins
  input wire logic spi_clk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  input wire logic wp_n_in,
  // Nonvolatile store
  input wire logic nv_blank_in,
  input wire logic nv_protect_in,
  input wire logic nv_write_out,
  input wire logic nv_protect_out,
  // Array and status
  input wire logic erase_fail_in,
  input wire logic erase_active_out,
  input wire logic array_write_allowed_out,
  input wire flash_cmd_pkg::status_s status_out
);
  import flash_cmd_pkg::*;
  localparam int ERASE_CYCLES = (CHIP_ERASE_TIME + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  logic wr_latch;
  logic prot;
  logic lock;
  logic busy;
  int act_cnt;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  // Short names for the status fields
  assign wr_latch = status_out.write_enable_latch;
  assign prot = status_out.array_protect_bit;
  assign lock = status_out.protect_lock_bit;
  assign busy = status_out.busy;
  // Length of the current erase pulse, so the exact duration can be checked
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || !erase_active_out) begin
      act_cnt <= 0;
    end else begin
      act_cnt <= act_cnt + 1;
    end
  end
  sequence erase_start_s;
    $rose(erase_active_out);
  endsequence
  busy_match_a: assert property (erase_active_out |-> busy)
    else $error("busy low during erase");
  erase_len_a: assert property ($fell(erase_active_out) |-> act_cnt == ERASE_CYCLES)
    else $error("erase length wrong");
  busy_end_a: assert property ($fell(erase_active_out) |-> busy ##1 !busy)
    else $error("busy not ended after erase");
  latch_clear_a: assert property (erase_start_s |-> !wr_latch)
    else $error("latch kept at erase start");
  erase_gate_a: assert property (erase_start_s |-> $past(wr_latch) && !$past(prot))
    else $error("erase started without latch or while protected");
  allowed_eq_a: assert property (array_write_allowed_out == (wr_latch && !prot && !busy))
    else $error("write allowed wrong");
  lock_freeze_a: assert property ($past(status_out.hw_locked) |-> $stable(prot) && $stable(lock))
    else $error("bits changed while locked");
  nv_pulse_a: assert property (nv_write_out |-> nv_protect_out == prot ##1 !nv_write_out)
    else $error("store pulse wrong");
  fail_flag_a: assert property (erase_active_out && erase_fail_in |=> status_out.erase_program_error_flag)
    else $error("error flag not set");
  latch_release_a: assert property ($changed(wr_latch) |-> $past(cs_n_in, 2))
    else $error("latch changed inside frame");
endmodule : flash_erase_protect_cmds_chk
bind flash_erase_protect_cmds flash_erase_protect_cmds_chk #(.CHIP_ERASE_TIME(CHIP_ERASE_TIME)) u_chk (
  .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .spi_clk_in(spi_clk_in), .cs_n_in(cs_n_in),
  .sdi_in(sdi_in), .wp_n_in(wp_n_in), .nv_blank_in(nv_blank_in), .nv_protect_in(nv_protect_in),
  .nv_write_out(nv_write_out), .nv_protect_out(nv_protect_out), .erase_fail_in(erase_fail_in),
  .erase_active_out(erase_active_out), .array_write_allowed_out(array_write_allowed_out),
  .status_out(status_out));
`default_nettype wire

// ==== sim/spi_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // Serial link toward the device
  output logic spi_clk_out,
  output logic cs_n_out,
  output logic sdi_out
);
  // Idle link: clock low, select high
  initial begin
    spi_clk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // Mode 0 frame, MSB first; the clock stands still outside frames
  task automatic send_frame(input logic [15:0] bits, input int nbits);
    #1; // Keep select off the system clock edge the caller returned on
    cs_n_out = 1'b0;
    #83;
    for (int i = 0; i < nbits; i++) begin
      sdi_out = bits[15 - i];
      #80 spi_clk_out = 1'b1;
      #80 spi_clk_out = 1'b0;
    end
    #40 cs_n_out = 1'b1;
    sdi_out = ~sdi_out; // Released line must not look like held data
  endtask : send_frame
endmodule : spi_host_model
`default_nettype wire

// ==== sim/flash_erase_protect_cmds_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module flash_erase_protect_cmds_tb_top;
  import flash_cmd_pkg::*;
  localparam int ERASE_CYC = 100 / CLK_PERIOD_NS;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic wp_n_in = 1'b1;
  logic nv_blank_in = 1'b1;
  logic nv_protect_in = 1'b0;
  logic erase_fail_in = 1'b0;
  wire logic spi_clk;
  wire logic cs_n;
  wire logic sdi;
  status_s st;
  logic nv_write;
  logic nv_prot;
  logic erase_act;
  logic allowed;
  logic seen = 1'b0;
  int err_total = 0;
  int samples_checked = 0;
  // Clock and erase-seen flag
  always #2.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (erase_act) seen <= 1'b1;
  spi_host_model host (.spi_clk_out(spi_clk), .cs_n_out(cs_n), .sdi_out(sdi));
  flash_erase_protect_cmds #(.CHIP_ERASE_TIME(100)) dut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .spi_clk_in(spi_clk), .cs_n_in(cs_n),
    .sdi_in(sdi), .wp_n_in(wp_n_in), .nv_blank_in(nv_blank_in), .nv_protect_in(nv_protect_in),
    .nv_write_out(nv_write), .nv_protect_out(nv_prot), .erase_fail_in(erase_fail_in),
    .erase_active_out(erase_act), .array_write_allowed_out(allowed), .status_out(st));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim;
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : cyc
  // One frame, then enough idle for decode and the gap between frames
  task automatic cmd(input logic [15:0] b, input int n);
    host.send_frame(b, n);
    cyc(30);
  endtask : cmd
  task automatic do_reset(input logic blank, input logic nvp);
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b1;
    nv_blank_in <= blank;
    nv_protect_in <= nvp;
    cyc(12);
    sys_rst_in <= 1'b0;
    cyc(3);
    check({st.write_enable_latch, st.protect_lock_bit, st.busy, nv_prot}, 8'h00);
    check(st.array_protect_bit, !blank && nvp);
  endtask : do_reset
  task automatic t_latch;
    cmd({OP_WRITE_ENABLE, 8'hFF}, 16);
    check(st.write_enable_latch, 1'b1);
    check(allowed, 1'b1);
    cmd({OP_WRITE_DISABLE, 8'hFF}, 16);
    check(st.write_enable_latch, 1'b0);
    cmd({OP_WRITE_ENABLE, 8'h00}, 12);
    cmd({OP_WRITE_ENABLE, 8'h00}, 4);
    check(st.write_enable_latch, 1'b0);
    cmd({OP_WRITE_ENABLE, 8'h00}, 8);
    cmd({OP_WRITE_DISABLE, 8'h00}, 7);
    check(st.write_enable_latch, 1'b1);
  endtask : t_latch
  task automatic t_refused;
    seen = 1'b0;
    cmd({OP_CHIP_ERASE_A, 8'h00}, 4);
    check({seen, st.write_enable_latch}, 8'h01);
    cmd({OP_CHIP_ERASE_A, 8'h00}, 12);
    check({seen, st.write_enable_latch}, 8'h00);
    cmd({OP_CHIP_ERASE_B, 8'h00}, 8);
    check(seen, 1'b0);
  endtask : t_refused
  task automatic t_erase(input logic [7:0] op, input logic fail);
    int n;
    cmd({OP_WRITE_ENABLE, 8'h00}, 8);
    erase_fail_in <= fail;
    host.send_frame({op, 8'hA5}, 16);
    n = 0;
    while (erase_act !== 1'b1 && n < 20) begin
      @(negedge clk_sys_in) n++;
    end
    check({st.busy, st.write_enable_latch}, 8'h02);
    n = 0;
    while (erase_act === 1'b1 && n < 1000) begin
      @(negedge clk_sys_in) n++;
    end
    check(n[7:0], ERASE_CYC[7:0]);
    @(posedge clk_sys_in) erase_fail_in <= 1'b0;
    cyc(5);
    check({st.busy, st.erase_program_error_flag}, {7'h00, fail});
  endtask : t_erase
  task automatic t_protect;
    cmd({OP_WRITE_ENABLE, 8'h00}, 8);
    cmd({OP_STATUS_WRITE, 8'h04}, 16);
    check({st.array_protect_bit, nv_prot}, 8'h03);
    cmd({OP_STATUS_WRITE, 8'h00}, 16);
    check(st.array_protect_bit, 1'b1);
    cmd({OP_WRITE_ENABLE, 8'h00}, 8);
    check(allowed, 1'b0);
    seen = 1'b0;
    cmd({OP_CHIP_ERASE_C, 8'h00}, 8);
    check({seen, st.write_enable_latch}, 8'h00);
  endtask : t_protect
  task automatic t_lock;
    cmd({OP_WRITE_ENABLE, 8'h00}, 8);
    cmd({OP_STATUS_WRITE, 8'h84}, 16);
    check({st.protect_lock_bit, st.array_protect_bit, st.hw_locked}, 8'h06);
    @(posedge clk_sys_in) wp_n_in <= 1'b0;
    cmd({OP_WRITE_ENABLE, 8'h00}, 8);
    cmd({OP_STATUS_WRITE, 8'h00}, 16);
    check({st.protect_lock_bit, st.array_protect_bit, st.hw_locked}, 8'h07);
    @(posedge clk_sys_in) wp_n_in <= 1'b1;
    cmd({OP_WRITE_ENABLE, 8'h00}, 8);
    cmd({OP_STATUS_WRITE, 8'h80}, 16);
    check({st.protect_lock_bit, st.array_protect_bit}, 8'h02);
    cmd({OP_WRITE_ENABLE, 8'h00}, 8);
    cmd({OP_STATUS_WRITE, 8'h00}, 16);
    check(st.protect_lock_bit, 1'b0);
  endtask : t_lock
  // Main sequence, ending with a mid-run reset that reloads the stored bit
  initial begin
    do_reset(1'b1, 1'b0);
    t_latch();
    t_refused();
    t_erase(OP_CHIP_ERASE_A, 1'b0);
    t_erase(OP_CHIP_ERASE_B, 1'b0);
    t_erase(OP_CHIP_ERASE_C, 1'b1);
    t_protect();
    t_lock();
    do_reset(1'b0, 1'b1);
    end_sim();
  end
  // Watchdog well beyond the expected run of about 58 us, under 100k cycles
  initial begin
    #400000;
    err_total++;
    end_sim();
  end
endmodule : flash_erase_protect_cmds_tb_top
`default_nettype wire
